//--- daq_pkg.sv
/*
  Package for the data acquisition I/O register file: register offsets,
  field positions, reset values, timing constants and carrier structs.
  Assumes one 250 MHz clock and an 8-bit register port.
*/
package daq_pkg;

  // Register offsets (4-bit register index)
  localparam logic [3:0] OFF_FIFO_THRESHOLD = 4'h5;
  localparam logic [3:0] OFF_DAC_LOW_FIFO = 4'h6;
  localparam logic [3:0] OFF_DAC_HIGH_STATUS = 4'h7;
  localparam logic [3:0] OFF_PORT_A = 4'h8;
  localparam logic [3:0] OFF_PORT_B = 4'h9;
  localparam logic [3:0] OFF_PORT_C = 4'hA;
  localparam logic [3:0] OFF_PORT_CTRL = 4'hB;
  localparam logic [3:0] OFF_CNT_LOW = 4'hC;
  localparam logic [3:0] OFF_CNT_MID = 4'hD;
  localparam logic [3:0] OFF_CNT_HIGH = 4'hE;
  localparam logic [3:0] OFF_CNT_CMD = 4'hF;

  // Port control fields
  localparam int CTL_PIN_SHARE = 7;
  localparam int CTL_A_IN = 4;
  localparam int CTL_CU_IN = 3;
  localparam int CTL_B_IN = 1;
  localparam int CTL_CL_IN = 0;
  localparam logic [7:0] CTL_RESET = 8'h9B;

  // Counter command fields
  localparam int CMD_SEL = 7;
  localparam int CMD_LATCH = 6;
  localparam int CMD_GATE_OFF = 5;
  localparam int CMD_GATE_ON = 4;
  localparam int CMD_COUNT_OFF = 3;
  localparam int CMD_COUNT_ON = 2;
  localparam int CMD_LOAD = 1;
  localparam int CMD_ZERO = 0;

  // FIFO threshold limits and reset
  localparam logic [5:0] THR_MAX = 6'h30;
  localparam logic [5:0] THR_MIN = 6'h01;
  localparam logic [5:0] THR_RESET = 6'h01;

  // DAC update time
  localparam int CLK_MHZ = 250;
  localparam int DAC_UPDATE_US = 20;
  localparam int DAC_UPDATE_CYCLES = DAC_UPDATE_US * CLK_MHZ;

  typedef struct packed {
    logic [1:0] channel;
    logic [11:0] value;
  } daq_dac_word_type;

  typedef struct packed {
    logic dma;
    logic timer;
    logic dio;
    logic adc;
  } daq_irq_type;

endpackage

//--- daq_io_register_file.sv
/*
  Upper register bank (offsets 5..15) of a data acquisition controller:
  FIFO threshold/depth, DAC staging, interrupt status, three digital
  ports with counter pin sharing, and a 24-bit and a 16-bit down-counter.
  Assumes a single-cycle strobe register port, FIFO/ADC/DAC/IRQ sources
  in the same clock domain, and asynchronous pins for ports, gates, clock.
*/
// Added by the designer: strobed register access.
`timescale 1ns/1ps

module daq_io_register_file
  import daq_pkg::*;
#(
  parameter int DAC_CYCLES = DAC_UPDATE_CYCLES
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [5:0] fifo_fill_count_i,
  input wire logic [3:0] next_sample_channel_i,
  input wire logic dma_event_i,
  input wire logic timer_event_i,
  input wire logic dio_event_i,
  input wire daq_irq_type irq_clear_i,
  output logic irq_o,
  output logic [5:0] fifo_irq_level_o,
  output daq_dac_word_type dac_word_o,
  output logic dac_start_o,
  output logic dac_update_busy_o,
  input wire logic [7:0] port_a_i,
  output logic [7:0] port_a_o,
  output logic [7:0] port_a_oe_o,
  input wire logic [7:0] port_b_i,
  output logic [7:0] port_b_o,
  output logic [7:0] port_b_oe_o,
  input wire logic [7:0] port_c_i,
  output logic [7:0] port_c_o,
  output logic [7:0] port_c_oe_o,
  input wire logic counter0_clk_i
);

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] clamp_thr(input logic [7:0] v);
    logic [5:0] r;
    r = v[5:0];
    if (v > {2'h0, THR_MAX}) begin
      r = THR_MAX;
    end else if (v == 8'h00) begin
      r = THR_MIN;
    end
    return r;
  endfunction

  localparam logic [12:0] DAC_LAST = 13'(DAC_CYCLES - 1);

  logic wr_thr, wr_dac_lo, wr_dac_hi, wr_pa, wr_pb, wr_pc, wr_ctl;
  logic wr_cl, wr_cm, wr_ch, wr_cmd;
  assign wr_thr = wr_i && addr_i == OFF_FIFO_THRESHOLD;
  assign wr_dac_lo = wr_i && addr_i == OFF_DAC_LOW_FIFO;
  assign wr_dac_hi = wr_i && addr_i == OFF_DAC_HIGH_STATUS;
  assign wr_pa = wr_i && addr_i == OFF_PORT_A;
  assign wr_pb = wr_i && addr_i == OFF_PORT_B;
  assign wr_pc = wr_i && addr_i == OFF_PORT_C;
  assign wr_ctl = wr_i && addr_i == OFF_PORT_CTRL;
  assign wr_cl = wr_i && addr_i == OFF_CNT_LOW;
  assign wr_cm = wr_i && addr_i == OFF_CNT_MID;
  assign wr_ch = wr_i && addr_i == OFF_CNT_HIGH;
  assign wr_cmd = wr_i && addr_i == OFF_CNT_CMD;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [7:0] pa_s1, pa_s2, pb_s1, pb_s2, pc_s1, pc_s2;
  logic [1:0] gate_s1, gate_s2;
  logic clk1_s1, clk1_s2, clk1_d;
  always_ff @(posedge mclk_i) begin
    pa_s1 <= port_a_i;
    pa_s2 <= pa_s1;
    pb_s1 <= port_b_i;
    pb_s2 <= pb_s1;
    pc_s1 <= port_c_i;
    pc_s2 <= pc_s1;
    gate_s1 <= port_c_i[5:4];
    gate_s2 <= gate_s1;
    clk1_s1 <= port_c_i[6];
    clk1_s2 <= clk1_s1;
    clk1_d <= clk1_s2;
  end

  //////////////////////////////////////////////////////////////////////////////
  // FIFO threshold and interrupt status
  logic [5:0] fifo_irq_level;
  daq_irq_type pend;
  logic fifo_hit, fifo_hit_d;
  assign fifo_hit = fifo_fill_count_i >= fifo_irq_level;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      fifo_irq_level <= THR_RESET;
    end else if (wr_thr) begin
      fifo_irq_level <= clamp_thr(wdata_i);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      fifo_hit_d <= 1'b0;
      pend <= '0;
    end else begin
      fifo_hit_d <= fifo_hit;
      // Set wins over a same-cycle clear
      pend.adc <= (fifo_hit && !fifo_hit_d) || (pend.adc && !irq_clear_i.adc);
      pend.dma <= dma_event_i || (pend.dma && !irq_clear_i.dma);
      pend.timer <= timer_event_i || (pend.timer && !irq_clear_i.timer);
      pend.dio <= dio_event_i || (pend.dio && !irq_clear_i.dio);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |pend;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // DAC staging and busy timer
  logic [7:0] dac_low;
  logic [12:0] dac_cnt;
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      dac_low <= 8'h00;
    end else if (wr_dac_lo) begin
      dac_low <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      dac_word_o <= '0;
      dac_start_o <= 1'b0;
    end else begin
      dac_start_o <= wr_dac_hi && !dac_update_busy_o;
      if (wr_dac_hi && !dac_update_busy_o) begin
        dac_word_o.channel <= wdata_i[7:6];
        dac_word_o.value <= {wdata_i[3:0], dac_low};
      end
    end
  end

  // A write while busy is dropped so the serial shift is never corrupted
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      dac_update_busy_o <= 1'b0;
      dac_cnt <= 13'h0000;
    end else if (wr_dac_hi && !dac_update_busy_o) begin
      dac_update_busy_o <= 1'b1;
      dac_cnt <= DAC_LAST;
    end else if (dac_cnt != 13'h0000) begin
      dac_cnt <= dac_cnt - 13'h0001;
    end else begin
      dac_update_busy_o <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Digital ports
  logic [7:0] pa_out, pb_out, pc_out, ctl;
  logic pin_share;
  assign pin_share = ctl[CTL_PIN_SHARE];

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      ctl <= CTL_RESET;
    end else if (wr_ctl) begin
      ctl <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      pa_out <= 8'h00;
      pb_out <= 8'h00;
      pc_out <= 8'h00;
    end else begin
      if (wr_pa) pa_out <= wdata_i;
      if (wr_pb) pb_out <= wdata_i;
      if (wr_pc) pc_out <= wdata_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counters
  logic [23:0] load_reg, cnt0, latch_val;
  logic [15:0] cnt1;
  logic [1:0] count_en, gate_en;
  logic [1:0] pulse;
  logic sel;
  assign sel = wdata_i[CMD_SEL];
  // Counter 0 counts each core clock cycle while counter0_clk_i is high; counter 1 on rising edges of its pin
  assign pulse[0] = counter0_clk_i;
  assign pulse[1] = clk1_s2 && !clk1_d && !pin_share;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      load_reg <= 24'h000000;
    end else begin
      if (wr_cl) load_reg[7:0] <= wdata_i;
      if (wr_cm) load_reg[15:8] <= wdata_i;
      if (wr_ch) load_reg[23:16] <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      count_en <= 2'h0;
      gate_en <= 2'h0;
    end else if (wr_cmd) begin
      if (wdata_i[CMD_COUNT_ON]) count_en[sel] <= 1'b1;
      if (wdata_i[CMD_COUNT_OFF]) count_en[sel] <= 1'b0;
      if (wdata_i[CMD_GATE_ON]) gate_en[sel] <= 1'b1;
      if (wdata_i[CMD_GATE_OFF]) gate_en[sel] <= 1'b0;
    end
  end

  logic [1:0] run;
  // Gate pins only reach the counters while shared for counter use
  assign run = count_en & (~gate_en | (gate_s2 & {2{!pin_share}}));

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      cnt0 <= 24'h000000;
    end else if (wr_cmd && !sel && wdata_i[CMD_LOAD]) begin
      cnt0 <= load_reg;
    end else if (wr_cmd && !sel && wdata_i[CMD_ZERO]) begin
      cnt0 <= 24'h000000;
    end else if (run[0] && pulse[0]) begin
      cnt0 <= cnt0 - 24'h000001;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      cnt1 <= 16'h0000;
    end else if (wr_cmd && sel && wdata_i[CMD_LOAD]) begin
      cnt1 <= load_reg[15:0];
    end else if (wr_cmd && sel && wdata_i[CMD_ZERO]) begin
      cnt1 <= 16'h0000;
    end else if (run[1] && pulse[1]) begin
      cnt1 <= cnt1 - 16'h0001;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      latch_val <= 24'h000000;
    end else if (wr_cmd && wdata_i[CMD_LATCH]) begin
      if (sel) begin
        latch_val[15:0] <= cnt1;
      end else begin
        latch_val <= cnt0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin drive, registered outputs
  logic out0;
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      out0 <= 1'b0;
    end else begin
      out0 <= cnt0 == 24'h000000;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      port_a_o <= 8'h00;
      port_a_oe_o <= 8'h00;
      port_b_o <= 8'h00;
      port_b_oe_o <= 8'h00;
      port_c_o <= 8'h00;
      port_c_oe_o <= 8'h00;
      fifo_irq_level_o <= THR_RESET;
    end else begin
      fifo_irq_level_o <= fifo_irq_level;
      port_a_o <= pa_out;
      port_a_oe_o <= {8{!ctl[CTL_A_IN]}};
      port_b_o <= pb_out;
      port_b_oe_o <= {8{!ctl[CTL_B_IN]}};
      port_c_oe_o[3:0] <= {4{!ctl[CTL_CL_IN]}};
      if (pin_share) begin
        port_c_o <= pc_out;
        port_c_oe_o[7:4] <= {4{!ctl[CTL_CU_IN]}};
      end else begin
        port_c_o <= {out0, pc_out[6:0]};
        port_c_oe_o[7:4] <= 4'h8;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        OFF_FIFO_THRESHOLD: rdata_o <= {2'h0, fifo_irq_level};
        OFF_DAC_LOW_FIFO: rdata_o <= {2'h0, fifo_fill_count_i};
        OFF_DAC_HIGH_STATUS: rdata_o <= {pend, next_sample_channel_i};
        OFF_PORT_A: rdata_o <= ctl[CTL_A_IN] ? pa_s2 : pa_out;
        OFF_PORT_B: rdata_o <= ctl[CTL_B_IN] ? pb_s2 : pb_out;
        OFF_PORT_C: rdata_o <= {ctl[CTL_CU_IN] ? pc_s2[7:4] : pc_out[7:4],
                                ctl[CTL_CL_IN] ? pc_s2[3:0] : pc_out[3:0]};
        OFF_PORT_CTRL: rdata_o <= ctl;
        OFF_CNT_LOW: rdata_o <= latch_val[7:0];
        OFF_CNT_MID: rdata_o <= latch_val[15:8];
        OFF_CNT_HIGH: rdata_o <= latch_val[23:16];
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule

//--- daq_io_register_file_assertions.sv
/* Port checker for daq_io_register_file.
   Assumes a bind from the test top, one clock and a sync low reset. */
`timescale 1ns/1ps
module daq_io_register_file_assertions
  import daq_pkg::*;
#(
  parameter int DAC_CYCLES = DAC_UPDATE_CYCLES
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [5:0] fifo_fill_count_i,
  input wire logic [3:0] next_sample_channel_i,
  input wire logic dma_event_i,
  input wire daq_irq_type irq_clear_i,
  input wire logic irq_o,
  input wire logic [5:0] fifo_irq_level_o,
  input wire daq_dac_word_type dac_word_o,
  input wire logic dac_start_o,
  input wire logic dac_update_busy_o,
  input wire logic [7:0] port_a_oe_o,
  input wire logic [7:0] port_c_oe_o
);
  int busy_len;
  logic dac_go;
  // A high byte written while busy is refused and starts nothing
  assign dac_go = wr_i && addr_i == OFF_DAC_HIGH_STATUS && !dac_update_busy_o;
  always_ff @(posedge mclk_i) begin
    busy_len <= dac_update_busy_o ? busy_len + 1 : 0;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////
  property p_thr; fifo_irq_level_o >= THR_MIN && fifo_irq_level_o <= THR_MAX; endproperty
  a_thr: assert property (p_thr) else $error("threshold out of range");
  property p_go; dac_go |=> dac_start_o && dac_update_busy_o; endproperty
  a_go: assert property (p_go) else $error("no dac start");
  property p_word; dac_go |=> dac_word_o.channel == $past(wdata_i[7:6])
    && dac_word_o.value[11:8] == $past(wdata_i[3:0]); endproperty
  a_word: assert property (p_word) else $error("dac word wrong");
  property p_len; $fell(dac_update_busy_o) |->
    busy_len >= DAC_CYCLES - 1 && busy_len <= DAC_CYCLES + 2; endproperty
  a_len: assert property (p_len) else $error("dac busy length");
  property p_fifo; rd_i && addr_i == OFF_DAC_LOW_FIFO |=>
    rdata_o == {2'b00, $past(fifo_fill_count_i)}; endproperty
  a_fifo: assert property (p_fifo) else $error("fifo depth read");
  property p_chan; rd_i && addr_i == OFF_DAC_HIGH_STATUS |=>
    rdata_o[3:0] == $past(next_sample_channel_i); endproperty
  a_chan: assert property (p_chan) else $error("channel read");
  property p_req; dma_event_i |-> ##[1:2] irq_o; endproperty
  a_req: assert property (p_req) else $error("no request");
  property p_hold; irq_o && irq_clear_i == '0 && $past(irq_clear_i) == '0 |=> irq_o;
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_dir; wr_i && addr_i == OFF_PORT_CTRL |->
    ##2 port_a_oe_o == {8{!$past(wdata_i[CTL_A_IN], 2)}}; endproperty
  a_dir: assert property (p_dir) else $error("port a direction");
  property p_share; wr_i && addr_i == OFF_PORT_CTRL && !wdata_i[CTL_PIN_SHARE] |->
    ##2 port_c_oe_o[7:4] == 4'h8; endproperty
  a_share: assert property (p_share) else $error("counter pins");
endmodule

//--- daq_host_model.sv
/* Host bus master on the 8-bit register port.
   Assumes the slave answers a read in the next cycle, never waits. */
`timescale 1ns/1ps
module daq_host_model (
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  output logic [3:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial begin
    addr_o = 4'h0;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Released lines show inverted data so a stale value cannot pass
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    {addr_o, wdata_o, wr_o} <= {a, d, 1'b1};
    @(posedge mclk_i);
    {addr_o, wdata_o, wr_o} <= {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    {addr_o, rd_o} <= {a, 1'b1};
    @(posedge mclk_i);
    {addr_o, rd_o} <= {~a, 1'b0};
    #1 d = rdata_i;
  endtask
endmodule

//--- daq_io_register_file_test.sv
/* Self-checking test of daq_io_register_file.
   Assumes the host model drives the bus and a short DAC count. */
`timescale 1ns/1ps
module daq_io_register_file_test
  import daq_pkg::*;
;
  localparam int DC = 20;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] addr_i;
  logic [7:0] wdata_i, rdata_o, port_a_o, port_a_oe_o, port_b_o, port_b_oe_o, port_c_o;
  logic [7:0] port_c_oe_o, port_a_i = 8'h00, port_b_i = 8'h00, port_c_i = 8'h00, v;
  logic wr_i, rd_i, irq_o, dac_start_o, dac_update_busy_o, counter0_clk_i = 1'b0;
  logic dma_event_i = 1'b0, timer_event_i = 1'b0, dio_event_i = 1'b0;
  logic [5:0] fifo_fill_count_i = 6'h00, fifo_irq_level_o;
  logic [3:0] next_sample_channel_i = 4'h0;
  daq_irq_type irq_clear_i = '0;
  daq_dac_word_type dac_word_o;
  int mismatches = 0;
  int samples_checked = 0;
  always #2 mclk_i = ~mclk_i;
  daq_io_register_file #(.DAC_CYCLES(DC)) i_daq_io_register_file (.*);
  daq_host_model i_daq_host_model (.mclk_i(mclk_i), .rdata_i(rdata_o), .addr_o(addr_i),
    .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic w(input logic [3:0] a, input logic [7:0] d);
    i_daq_host_model.wr(a, d);
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e, input string n);
    i_daq_host_model.rd(a, v);
    chk(n, v, e);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge mclk_i) counter0_clk_i <= 1'b1;
      @(posedge mclk_i) counter0_clk_i <= 1'b0;
    end
  endtask
  task automatic rcnt(input logic [23:0] e);
    rc(OFF_CNT_LOW, e[7:0], "cnt_lo");
    rc(OFF_CNT_MID, e[15:8], "cnt_mid");
    rc(OFF_CNT_HIGH, e[23:16], "cnt_hi");
  endtask
  ////////////////////////////////////////
  task automatic t_thr;
    logic [7:0] wv[4] = '{8'h00, 8'h31, 8'h30, 8'hFF};
    logic [7:0] ex[4] = '{8'h01, 8'h30, 8'h30, 8'h30};
    rc(OFF_PORT_CTRL, CTL_RESET, "ctl");
    rc(4'h2, 8'h00, "unmapped");
    rc(OFF_FIFO_THRESHOLD, 8'h01, "thr");
    foreach (wv[i]) begin
      w(OFF_FIFO_THRESHOLD, wv[i]);
      rc(OFF_FIFO_THRESHOLD, ex[i], "thr");
      chk("level", fifo_irq_level_o, ex[i]);
    end
    $display("threshold test done");
  endtask
  task automatic t_irq;
    w(OFF_FIFO_THRESHOLD, 8'h03);
    @(posedge mclk_i) fifo_fill_count_i <= 6'h02;
    next_sample_channel_i <= 4'h9;
    cyc(4);
    #1 chk("irq", irq_o, 1'b0);
    @(posedge mclk_i) fifo_fill_count_i <= 6'h03;
    cyc(4);
    #1 chk("irq", irq_o, 1'b1);
    rc(OFF_DAC_LOW_FIFO, 8'h03, "depth");
    @(posedge mclk_i) fifo_fill_count_i <= 6'h00;
    rc(OFF_DAC_HIGH_STATUS, 8'h19, "status");
    @(posedge mclk_i) irq_clear_i <= 4'h1;
    @(posedge mclk_i) irq_clear_i <= 4'h0;
    rc(OFF_DAC_HIGH_STATUS, 8'h09, "status");
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk_i) {dma_event_i, timer_event_i, dio_event_i} <= 3'(1 << i);
      @(posedge mclk_i) {dma_event_i, timer_event_i, dio_event_i} <= 3'h0;
      cyc(2);
      #1 chk("irq", irq_o, 1'b1);
      rc(OFF_DAC_HIGH_STATUS, {3'(1 << i), 5'h09}, "status");
      @(posedge mclk_i) irq_clear_i <= daq_irq_type'({3'(1 << i), 1'b0});
      @(posedge mclk_i) irq_clear_i <= 4'h0;
    end
    $display("interrupt test done");
  endtask
  task automatic t_dac;
    int n;
    w(OFF_DAC_LOW_FIFO, 8'hBC);
    #1 chk("busy", dac_update_busy_o, 1'b0);
    w(OFF_DAC_HIGH_STATUS, 8'h4A);
    #1 chk("start", dac_start_o, 1'b1);
    chk("word", dac_word_o, {2'h1, 12'hABC});
    w(OFF_DAC_HIGH_STATUS, 8'hC5);
    #1 chk("word", dac_word_o, {2'h1, 12'hABC});
    n = 0;
    while (dac_update_busy_o && n < DC + 8) begin
      @(posedge mclk_i);
      #1 n++;
    end
    chk("busy", dac_update_busy_o, 1'b0);
    // Busy stands DC cycles; two of them passed around the refused write
    chk("busy_len", 24'(n), 24'(DC - 2));
    w(OFF_DAC_HIGH_STATUS, 8'hC0);
    #1 chk("word", dac_word_o, {2'h3, 12'h0BC});
    $display("dac test done");
  endtask
  task automatic t_port;
    w(OFF_PORT_CTRL, 8'h00);
    w(OFF_PORT_A, 8'h5A);
    w(OFF_PORT_B, 8'hC3);
    cyc(2);
    #1 chk("a_oe", port_a_oe_o, 8'hFF);
    chk("a_out", port_a_o, 8'h5A);
    chk("b_oe", port_b_oe_o, 8'hFF);
    chk("b_out", port_b_o, 8'hC3);
    chk("c_oe", port_c_oe_o, 8'h8F);
    rc(OFF_PORT_A, 8'h5A, "a_rd");
    w(OFF_PORT_CTRL, 8'h90);
    w(OFF_PORT_C, 8'h6E);
    @(posedge mclk_i) port_a_i <= 8'h3C;
    cyc(3);
    #1 chk("c_oe", port_c_oe_o, 8'hFF);
    chk("c_out", port_c_o, 8'h6E);
    rc(OFF_PORT_A, 8'h3C, "a_pin");
    $display("port test done");
  endtask
  task automatic t_cnt;
    w(OFF_PORT_CTRL, 8'h1B);
    w(OFF_CNT_HIGH, 8'h12);
    w(OFF_CNT_MID, 8'h34);
    w(OFF_CNT_LOW, 8'h56);
    w(OFF_CNT_CMD, 8'h02);
    w(OFF_CNT_CMD, 8'h10);
    w(OFF_CNT_CMD, 8'h04);
    pulse(3);
    @(posedge mclk_i) port_c_i <= 8'h10;
    cyc(4);
    pulse(3);
    @(posedge mclk_i) port_c_i <= 8'h00;
    w(OFF_CNT_CMD, 8'h20);
    pulse(2);
    w(OFF_CNT_CMD, 8'h08);
    pulse(2);
    w(OFF_CNT_CMD, 8'h40);
    w(OFF_CNT_LOW, 8'hAA);
    rcnt(24'h123451);
    w(OFF_CNT_CMD, 8'h40);
    rcnt(24'h123451);
    w(OFF_CNT_MID, 8'h9A);
    w(OFF_CNT_LOW, 8'h78);
    w(OFF_CNT_CMD, 8'h82);
    w(OFF_CNT_CMD, 8'hC0);
    rcnt(24'h129A78);
    w(OFF_CNT_CMD, 8'h84);
    // Two rising edges on the shared clock pin of counter 1
    repeat (2) begin
      @(posedge mclk_i) port_c_i <= 8'h40;
      cyc(3);
      @(posedge mclk_i) port_c_i <= 8'h00;
      cyc(3);
    end
    w(OFF_CNT_CMD, 8'hC0);
    rcnt(24'h129A76);
    w(OFF_CNT_CMD, 8'h81);
    w(OFF_CNT_CMD, 8'hC0);
    rcnt(24'h120000);
    w(OFF_CNT_CMD, 8'h01);
    w(OFF_CNT_CMD, 8'h40);
    rcnt(24'h000000);
    chk("out0", port_c_o[7], 1'b1);
    chk("c_out", port_c_o, 8'hEE);
    chk("c_oe", port_c_oe_o, 8'h80);
    chk("a_oe", port_a_oe_o, 8'h00);
    chk("b_oe", port_b_oe_o, 8'h00);
    $display("counter test done");
  endtask
  ////////////////////////////////////////
  initial begin
    cyc(16);
    nrst_i <= 1'b1;
    t_thr();
    t_irq();
    t_dac();
    t_port();
    t_cnt();
    finish_test();
  end
  initial begin
    cyc(20000);
    mismatches++;
    $display("timeout");
    finish_test();
  end
endmodule
bind daq_io_register_file daq_io_register_file_assertions #(.DAC_CYCLES(DAC_CYCLES))
  i_daq_io_register_file_assertions (.*);
